// *** logic/brn_rtc_top.sv ***
// byte-wide memory with clock and calendar in the top eight bytes
// assumes an asynchronous host bus held stable per cycle, oscillator on a pin
`timescale 1ns/1ps
module brn_rtc_top #(
	parameter int ADDR_W = brn_pkg::ADDR_W,
	parameter int DATA_W = brn_pkg::DATA_W
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// host memory bus
	input  wire logic [ADDR_W-1:0] address_pins,
	input  wire logic              chip_sel_b,
	input  wire logic              out_drive_b,
	input  wire logic              write_strobe_b,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe,
	// supply and oscillator status pins
	input  wire logic              power_fail,
	input  wire logic              battery_ok_pin,
	input  wire logic              osc_clk_pin
);

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int SYNC_W = ADDR_W + DATA_W + 6;

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic              ce_b_s;
	logic              oe_b_s;
	logic              we_b_s;
	logic              pf_s;
	logic              batt_s;
	logic              osc_s;

	// reset to ones: deselected and power-failed until real samples arrive
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end
		else
		begin
			sync1_reg <= {address_pins, data_in, chip_sel_b, out_drive_b, write_strobe_b,
				power_fail, battery_ok_pin, osc_clk_pin};
			sync2_reg <= sync1_reg;
		end
	end

	// only the second stage is read; multi-bit address relies on host holding it
	assign {addr_s, data_s, ce_b_s, oe_b_s, we_b_s, pf_s, batt_s, osc_s} = sync2_reg;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic is_tk(input logic [ADDR_W-1:0] a);
		return a >= ADDR_W'(brn_pkg::TK_BASE);
	endfunction : is_tk

	function automatic int byte_lsb(input logic [brn_pkg::TK_IDX_W-1:0] idx);
		return int'(idx) * brn_pkg::DATA_W;
	endfunction : byte_lsb

	// ****************************************
	// bus cycle decode
	// ****************************************
	logic rd_cond;
	logic wr_cond;

	// power fail blocks every control input
	assign rd_cond = !pf_s && !ce_b_s && !oe_b_s && we_b_s;
	assign wr_cond = !pf_s && !ce_b_s && !we_b_s;

	// ****************************************
	// write capture
	// ****************************************
	logic              wr_act_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic              commit;

	// data taken on the last cycle of the overlap, like a static ram
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			wr_act_reg <= 1'b0;
			waddr_reg  <= '0;
			wdata_reg  <= '0;
		end
		else
		begin
			wr_act_reg <= wr_cond;
			if (wr_cond)
			begin
				waddr_reg <= addr_s;
				wdata_reg <= data_s;
			end
		end
	end

	// a write cut short by power fail is dropped, not committed
	assign commit = wr_act_reg && !wr_cond && !pf_s;

	// ****************************************
	// plain storage
	// ****************************************
	logic [DATA_W-1:0] ram_rdata;
	logic              ram_we;

	assign ram_we = commit && !is_tk(waddr_reg);

	brn_ram #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) i_brn_ram (
		.ref_clk (ref_clk),
		.wr_en   (ram_we),
		.wr_addr (waddr_reg),
		.wr_data (wdata_reg),
		.rd_addr (addr_s),
		.rd_data (ram_rdata)
	);

	// ****************************************
	// oscillator time base
	// ****************************************
	logic                       osc_d_reg;
	logic [brn_pkg::PRESC_W-1:0] presc_reg;
	logic                       sec_tick_reg;
	logic                       osc_rise;
	logic                       osc_stop;
	logic                       load_pend_reg;
	logic [63:0]                vis_reg;

	assign osc_stop = vis_reg[byte_lsb(brn_pkg::TK_IDX_W'(brn_pkg::IDX_SECONDS)) + brn_pkg::BIT_OSC_STOP];
	assign osc_rise = osc_s && !osc_d_reg && !osc_stop;

	// edge detect on the synchronised oscillator; resets high like the synchroniser
	// so that the release of reset is not taken for a rising edge
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			osc_d_reg <= 1'b1;
		else
			osc_d_reg <= osc_s;
	end

	// binary divider; a set restarts the second so it begins whole
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			presc_reg    <= brn_pkg::PRESC_ZERO;
			sec_tick_reg <= 1'b0;
		end
		else if (load_pend_reg)
		begin
			presc_reg    <= brn_pkg::PRESC_ZERO;
			sec_tick_reg <= 1'b0;
		end
		else
		begin
			sec_tick_reg <= osc_rise && (presc_reg == brn_pkg::PRESC_LAST);
			if (osc_rise)
				presc_reg <= (presc_reg == brn_pkg::PRESC_LAST) ? brn_pkg::PRESC_ZERO
					: presc_reg + 15'h0001;
		end
	end

	// ****************************************
	// internal counters
	// ****************************************
	logic [63:0] cnt_val;

	brn_cal_count i_brn_cal_count (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.sec_tick (sec_tick_reg),
		.load     (load_pend_reg),
		.load_val (vis_reg),
		.cnt_val  (cnt_val)
	);

	// ****************************************
	// host-visible clock bytes
	// ****************************************
	logic       hold;
	logic [7:0] cent_byte;
	logic       tk_write;
	logic [brn_pkg::TK_IDX_W-1:0] widx;

	assign cent_byte = vis_reg[byte_lsb(brn_pkg::TK_IDX_W'(brn_pkg::IDX_CENTURY)) +: 8];
	assign hold      = cent_byte[brn_pkg::BIT_READ_HOLD] || cent_byte[brn_pkg::BIT_SET_HOLD];
	assign tk_write  = commit && is_tk(waddr_reg);
	assign widx      = waddr_reg[brn_pkg::TK_IDX_W-1:0];

	// copy all counting bits at once; control and spare bits stay storage
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			vis_reg <= brn_pkg::TK_RESET;
		else
		begin
			if (!hold && !load_pend_reg)
				vis_reg <= (vis_reg & ~brn_pkg::TIME_MASK) | (cnt_val & brn_pkg::TIME_MASK);
			if (tk_write)
				vis_reg[byte_lsb(widx) +: 8] <= wdata_reg;
		end
	end

	// clearing the set-hold bit by a write loads the counters next cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			load_pend_reg <= 1'b0;
		else
			load_pend_reg <= tk_write && (widx == brn_pkg::TK_IDX_W'(brn_pkg::IDX_CENTURY))
				&& cent_byte[brn_pkg::BIT_SET_HOLD] && !wdata_reg[brn_pkg::BIT_SET_HOLD];
	end

	// ****************************************
	// read path
	// ****************************************
	logic                         rsel_tk_reg;
	logic [brn_pkg::TK_IDX_W-1:0] ridx_reg;
	logic [7:0]                   rd_tk;
	logic                         ft_on;
	logic [DATA_W-1:0]            data_out_reg;
	logic                         data_oe_reg;

	assign ft_on = vis_reg[byte_lsb(brn_pkg::TK_IDX_W'(brn_pkg::IDX_DAY)) + brn_pkg::BIT_FREQ_TEST] && !osc_stop;

	// battery and test-tone bits are overlaid on the stored byte at read time
	always_comb
	begin
		rd_tk = vis_reg[byte_lsb(ridx_reg) +: 8];
		if (ridx_reg == brn_pkg::TK_IDX_W'(brn_pkg::IDX_DAY))
			rd_tk[brn_pkg::BIT_BATT_OK] = batt_s;
		if (ridx_reg == brn_pkg::TK_IDX_W'(brn_pkg::IDX_SECONDS) && ft_on)
			rd_tk[brn_pkg::BIT_SEC_LSB] = presc_reg[brn_pkg::FT_BIT];
	end

	// select follows the ram's one-cycle read latency
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rsel_tk_reg <= 1'b0;
			ridx_reg    <= '0;
		end
		else
		begin
			rsel_tk_reg <= is_tk(addr_s);
			ridx_reg    <= addr_s[brn_pkg::TK_IDX_W-1:0];
		end
	end

	// enable leads data by one cycle: first byte is stale, as before access time
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			data_out_reg <= '0;
			data_oe_reg  <= 1'b0;
		end
		else
		begin
			data_out_reg <= rsel_tk_reg ? rd_tk : ram_rdata;
			data_oe_reg  <= rd_cond;
		end
	end

	assign data_out = data_out_reg;
	assign data_oe  = data_oe_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_PF_NO_DRIVE: assert property (pf_s |=> !data_oe_reg)
		else $error("data pins driven during power fail");
	AST_PF_NO_STORE: assert property (pf_s && $past(pf_s) |=> $stable(vis_reg & ~brn_pkg::TIME_MASK) && !ram_we)
		else $error("storage changed during power fail");
	AST_DRIVE_ONLY_READ: assert property (data_oe_reg |-> $past(!ce_b_s && !oe_b_s && we_b_s))
		else $error("data pins driven outside a read");
	AST_HOLD_FREEZE: assert property (hold && !tk_write |=> (vis_reg & brn_pkg::TIME_MASK)
		== $past(vis_reg & brn_pkg::TIME_MASK))
		else $error("visible time moved while held");
	AST_RELEASE_REFRESH: assert property (!hold && !load_pend_reg && !tk_write |=> (vis_reg & brn_pkg::TIME_MASK)
		== $past(cnt_val & brn_pkg::TIME_MASK))
		else $error("visible time not refreshed from counters");
	AST_SET_LOAD: assert property (load_pend_reg |=> cnt_val == $past(vis_reg & brn_pkg::TIME_MASK))
		else $error("counters not loaded on set release");
	AST_COUNT_ON_HOLD: assert property (sec_tick_reg && !load_pend_reg |=> cnt_val != $past(cnt_val))
		else $error("counters did not advance on second");
	AST_OSC_STOP: assert property (osc_stop && !load_pend_reg |=> $stable(presc_reg))
		else $error("divider ran with oscillator stopped");
	AST_SEC_PERIOD: assert property (sec_tick_reg |-> $past(presc_reg) == brn_pkg::PRESC_LAST)
		else $error("second pulse not at divider wrap");
	AST_FT_READ: assert property (rsel_tk_reg && ridx_reg == brn_pkg::TK_IDX_W'(brn_pkg::IDX_SECONDS) && ft_on
		|=> data_out_reg[brn_pkg::BIT_SEC_LSB] == $past(presc_reg[brn_pkg::FT_BIT]))
		else $error("test tone missing on seconds read");
	AST_BATT_READ: assert property (rsel_tk_reg && ridx_reg == brn_pkg::TK_IDX_W'(brn_pkg::IDX_DAY)
		|=> data_out_reg[brn_pkg::BIT_BATT_OK] == $past(batt_s))
		else $error("battery bit not reported");

	COV_SET_LOAD:   cover property (tk_write ##1 load_pend_reg ##1 !hold);
	COV_HOLD_CYCLE: cover property (hold ##1 sec_tick_reg ##[1:4] !hold);
	COV_FT_READ:    cover property (rd_cond && ft_on && rsel_tk_reg);

endmodule : brn_rtc_top

// *** logic/brn_pkg.sv ***
// constants shared by the byte-wide clock and memory block
// assumes a single 40 MHz core clock and a 32.768 kHz oscillator pin
package brn_pkg;

	// ****************************************
	// memory geometry
	// ****************************************
	localparam int              ADDR_W    = 17;
	localparam int              DATA_W    = 8;
	localparam int              TK_IDX_W  = 3;
	localparam logic [16:0]     TK_BASE   = 17'h1fff8;

	// ****************************************
	// timekeeping byte index from the base
	// ****************************************
	localparam int              IDX_CENTURY = 0;
	localparam int              IDX_SECONDS = 1;
	localparam int              IDX_MINUTES = 2;
	localparam int              IDX_HOURS   = 3;
	localparam int              IDX_DAY     = 4;
	localparam int              IDX_DATE    = 5;
	localparam int              IDX_MONTH   = 6;
	localparam int              IDX_YEAR    = 7;

	// ****************************************
	// control bit positions
	// ****************************************
	localparam int              BIT_SET_HOLD  = 7;
	localparam int              BIT_READ_HOLD = 6;
	localparam int              BIT_OSC_STOP  = 7;
	localparam int              BIT_FREQ_TEST = 6;
	localparam int              BIT_BATT_OK   = 7;
	localparam int              BIT_SEC_LSB   = 0;

	// counting bits per byte, byte i at [8i+:8]; others are plain storage
	localparam logic [63:0]     TIME_MASK = 64'hff1f3f073f7f7f3f;
	localparam logic [63:0]     TK_RESET  = 64'h0001010100000000;

	// ****************************************
	// bcd limits
	// ****************************************
	localparam logic [7:0]      BCD_ZERO  = 8'h00;
	localparam logic [7:0]      BCD_ONE   = 8'h01;
	localparam logic [3:0]      DIGIT_MAX = 4'h9;
	localparam logic [3:0]      DIGIT_ONE = 4'h1;
	localparam logic [7:0]      SEC_MAX   = 8'h59;
	localparam logic [7:0]      MIN_MAX   = 8'h59;
	localparam logic [7:0]      HOUR_MAX  = 8'h23;
	localparam logic [7:0]      WDAY_MAX  = 8'h07;
	localparam logic [7:0]      MONTH_MAX = 8'h12;
	localparam logic [7:0]      YEAR_MAX  = 8'h99;
	localparam logic [7:0]      CENT_MAX  = 8'h39;
	localparam logic [7:0]      MON_FEB   = 8'h02;
	localparam logic [7:0]      MON_APR   = 8'h04;
	localparam logic [7:0]      MON_JUN   = 8'h06;
	localparam logic [7:0]      MON_SEP   = 8'h09;
	localparam logic [7:0]      MON_NOV   = 8'h11;
	localparam logic [7:0]      DAYS_28   = 8'h28;
	localparam logic [7:0]      DAYS_29   = 8'h29;
	localparam logic [7:0]      DAYS_30   = 8'h30;
	localparam logic [7:0]      DAYS_31   = 8'h31;

	// ****************************************
	// oscillator division
	// ****************************************
	localparam int              OSC_HZ     = 32768;
	localparam int              FT_HZ      = 512;
	localparam int              PRESC_W    = $clog2(OSC_HZ);
	localparam int              FT_BIT     = $clog2(OSC_HZ / (2 * FT_HZ));
	localparam logic [14:0]     PRESC_LAST = 15'(OSC_HZ - 1);
	localparam logic [14:0]     PRESC_ZERO = 15'h0000;

endpackage : brn_pkg

// *** logic/brn_ram.sv ***
// byte-wide storage array with one write port and a registered read
// assumes write and read addresses are stable on the core clock
`timescale 1ns/1ps
module brn_ram #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 8
) (
	// clock
	input  wire logic              ref_clk,
	// write port
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// read port
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// no reset: contents survive, like battery-held storage
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : brn_ram

// *** logic/brn_cal_count.sv ***
// internal bcd time and calendar counters, free of host access
// assumes a one-cycle second pulse and a one-cycle load pulse
`timescale 1ns/1ps
module brn_cal_count (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// control
	input  wire logic        sec_tick,
	input  wire logic        load,
	input  wire logic [63:0] load_val,
	// counter state, byte i at [8i+:8]
	output logic      [63:0] cnt_val
);

	localparam int S = brn_pkg::IDX_SECONDS * 8;
	localparam int M = brn_pkg::IDX_MINUTES * 8;
	localparam int H = brn_pkg::IDX_HOURS * 8;
	localparam int W = brn_pkg::IDX_DAY * 8;
	localparam int D = brn_pkg::IDX_DATE * 8;
	localparam int O = brn_pkg::IDX_MONTH * 8;
	localparam int Y = brn_pkg::IDX_YEAR * 8;
	localparam int C = brn_pkg::IDX_CENTURY * 8;

	logic [63:0] cnt_next;
	logic [7:0]  dim;

	// next bcd value; out-of-range loads also wrap rather than stick
	function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] vmax, input logic [7:0] vmin);
		if (v >= vmax)
			return vmin;
		else if (v[3:0] >= brn_pkg::DIGIT_MAX)
			return {v[7:4] + brn_pkg::DIGIT_ONE, 4'h0};
		else
			return v + brn_pkg::BCD_ONE;
	endfunction : bcd_next

	// bcd value divisible by four: 2*tens+ones low bits zero
	function automatic logic bcd_div4(input logic [7:0] v);
		return !v[0] && (v[1] == v[4]);
	endfunction : bcd_div4

	// days in month with leap correction
	always_comb
	begin
		unique case (cnt_val[O+:8])
			brn_pkg::MON_FEB:
				dim = (bcd_div4(cnt_val[Y+:8]) && (cnt_val[Y+:8] != brn_pkg::BCD_ZERO || bcd_div4(cnt_val[C+:8])))
					? brn_pkg::DAYS_29 : brn_pkg::DAYS_28;
			brn_pkg::MON_APR, brn_pkg::MON_JUN, brn_pkg::MON_SEP, brn_pkg::MON_NOV:
				dim = brn_pkg::DAYS_30;
			default:
				dim = brn_pkg::DAYS_31;
		endcase
	end

	// carry chain from seconds up to century, 24-hour form
	always_comb
	begin
		cnt_next = cnt_val;
		cnt_next[S+:8] = bcd_next(cnt_val[S+:8], brn_pkg::SEC_MAX, brn_pkg::BCD_ZERO);
		if (cnt_val[S+:8] >= brn_pkg::SEC_MAX)
		begin
			cnt_next[M+:8] = bcd_next(cnt_val[M+:8], brn_pkg::MIN_MAX, brn_pkg::BCD_ZERO);
			if (cnt_val[M+:8] >= brn_pkg::MIN_MAX)
			begin
				cnt_next[H+:8] = bcd_next(cnt_val[H+:8], brn_pkg::HOUR_MAX, brn_pkg::BCD_ZERO);
				if (cnt_val[H+:8] >= brn_pkg::HOUR_MAX)
				begin
					cnt_next[W+:8] = bcd_next(cnt_val[W+:8], brn_pkg::WDAY_MAX, brn_pkg::BCD_ONE);
					cnt_next[D+:8] = bcd_next(cnt_val[D+:8], dim, brn_pkg::BCD_ONE);
					if (cnt_val[D+:8] >= dim)
					begin
						cnt_next[O+:8] = bcd_next(cnt_val[O+:8], brn_pkg::MONTH_MAX, brn_pkg::BCD_ONE);
						if (cnt_val[O+:8] >= brn_pkg::MONTH_MAX)
						begin
							cnt_next[Y+:8] = bcd_next(cnt_val[Y+:8], brn_pkg::YEAR_MAX, brn_pkg::BCD_ZERO);
							if (cnt_val[Y+:8] >= brn_pkg::YEAR_MAX)
							begin
								cnt_next[C+:8] = bcd_next(cnt_val[C+:8], brn_pkg::CENT_MAX, brn_pkg::BCD_ZERO);
							end
						end
					end
				end
			end
		end
	end

	// load wins over the second pulse so a set is never half counted
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			cnt_val <= brn_pkg::TK_RESET & brn_pkg::TIME_MASK;
		else if (load)
			cnt_val <= load_val & brn_pkg::TIME_MASK;
		else if (sec_tick)
			cnt_val <= cnt_next;
	end

endmodule : brn_cal_count

// *** dv/brn_host_model.sv ***
// host bus master model for the byte-wide clock and memory pins
// assumes the bench resolves the data wire; pins change by non-blocking on ref_clk rise
`timescale 1ns/1ps
module brn_host_model (
	// clock
	input  wire logic        ref_clk,
	// bus to device
	output logic      [16:0] address_pins,
	output logic             chip_sel_b,
	output logic             out_drive_b,
	output logic             write_strobe_b,
	output logic      [7:0]  host_dq,
	// resolved data wire
	input  wire logic [7:0]  data_bus,
	input  wire logic        data_oe
);
	// idle deselected
	initial
	begin
		address_pins   = 17'h00000;
		chip_sel_b     = 1'b1;
		out_drive_b    = 1'b1;
		write_strobe_b = 1'b1;
		host_dq        = 8'h00;
	end

	// write: 6-cycle phases, well past the 3-cycle sync floor
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		address_pins   <= a;
		host_dq        <= d;
		chip_sel_b     <= 1'b0;
		write_strobe_b <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chip_sel_b     <= 1'b1;
		write_strobe_b <= 1'b1;
		repeat (6) @(posedge ref_clk);
		host_dq        <= ~d; // released bus must not keep a stale value
	endtask : wr

	// read with output drive on or off, sampled after the access settles
	task automatic rd(input logic [16:0] a, input logic drv, output logic [7:0] q, output logic oe);
		@(posedge ref_clk);
		address_pins <= a;
		chip_sel_b   <= 1'b0;
		out_drive_b  <= ~drv;
		repeat (6) @(posedge ref_clk);
		q = data_bus;
		oe = data_oe;
		chip_sel_b   <= 1'b1;
		out_drive_b  <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : rd

	// continuous read counting changes of data bit 0
	task automatic watch(input logic [16:0] a, input int n, output int tg);
		logic b;
		tg = 0;
		@(posedge ref_clk);
		address_pins <= a;
		chip_sel_b   <= 1'b0;
		out_drive_b  <= 1'b0;
		repeat (6) @(posedge ref_clk);
		b = data_bus[0];
		repeat (n)
		begin
			@(posedge ref_clk);
			if (data_bus[0] !== b)
				tg++;
			b = data_bus[0];
		end
		chip_sel_b   <= 1'b1;
		out_drive_b  <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : watch
endmodule : brn_host_model

// *** dv/brn_rtc_top_tb.sv ***
// self-checking bench for the clock and memory block
// assumes brn_pkg compiled first; oscillator pin made at 12 ref_clk per period
`timescale 1ns/1ps
module brn_rtc_top_tb;
	logic        ref_clk;
	logic        rst_b;
	logic        power_fail;
	logic        battery_ok_pin;
	logic        osc_clk_pin;
	logic [16:0] address_pins;
	logic        chip_sel_b;
	logic        out_drive_b;
	logic        write_strobe_b;
	logic [7:0]  host_dq;
	logic [7:0]  data_out;
	logic        data_oe;
	logic [7:0]  bus_dq;
	logic [7:0]  q;
	logic        oe;
	int          mismatches;
	int          checks;
	int          cycles;
	int          osc_div;
	int          tg;
	localparam logic [16:0] TB = brn_pkg::TK_BASE;
	localparam logic [7:0]  RST_IMG [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h01, 8'h01, 8'h00};
	// month spare bit 7 set on purpose
	localparam logic [7:0]  SET_IMG [8] = '{8'h20, 8'h45, 8'h30, 8'h23, 8'h83, 8'h29, 8'h82, 8'h24};

	// resolved data wire
	assign bus_dq = data_oe ? data_out : host_dq;

	brn_rtc_top i_brn_rtc_top (
		.ref_clk(ref_clk), .rst_b(rst_b), .address_pins(address_pins), .chip_sel_b(chip_sel_b),
		.out_drive_b(out_drive_b), .write_strobe_b(write_strobe_b), .data_in(bus_dq),
		.data_out(data_out), .data_oe(data_oe), .power_fail(power_fail),
		.battery_ok_pin(battery_ok_pin), .osc_clk_pin(osc_clk_pin)
	);

	brn_host_model i_brn_host_model (
		.ref_clk(ref_clk), .address_pins(address_pins), .chip_sel_b(chip_sel_b),
		.out_drive_b(out_drive_b), .write_strobe_b(write_strobe_b), .host_dq(host_dq),
		.data_bus(bus_dq), .data_oe(data_oe)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// oscillator pin and hang limit
	always @(posedge ref_clk)
	begin
		osc_div <= (osc_div == 5) ? 0 : osc_div + 1;
		if (osc_div == 5)
			osc_clk_pin <= ~osc_clk_pin;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial
	begin
		rst_b = 1'b0;
		power_fail = 1'b0;
		battery_ok_pin = 1'b1;
		osc_clk_pin = 1'b0;
		osc_div = 0;
		cycles = 0;
		mismatches = 0;
		checks = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// clock bytes after reset
		for (int i = 0; i < 8; i++)
		begin
			i_brn_host_model.rd(TB + 17'(i), 1'b1, q, oe);
			check("reset byte", q, RST_IMG[i]);
		end
		// plain memory at the bottom and just under the clock bytes
		i_brn_host_model.wr(17'h00000, 8'h5a);
		i_brn_host_model.wr(17'h1fff7, 8'ha5);
		i_brn_host_model.rd(17'h00000, 1'b1, q, oe);
		check("ram low", q, 8'h5a);
		i_brn_host_model.rd(17'h1fff7, 1'b1, q, oe);
		check("ram top", q, 8'ha5);
		i_brn_host_model.rd(17'h00000, 1'b0, q, oe);
		check("drive off", {7'h00, oe}, 8'h00);
		// battery flag ignores a written zero and follows the pin
		i_brn_host_model.wr(TB + 17'h4, 8'h01);
		i_brn_host_model.rd(TB + 17'h4, 1'b1, q, oe);
		check("battery good", q, 8'h81);
		battery_ok_pin <= 1'b0;
		i_brn_host_model.rd(TB + 17'h4, 1'b1, q, oe);
		check("battery low", q, 8'h01);
		battery_ok_pin <= 1'b1;
		// set the clock: both holds, load bytes, release set-hold first, read-hold after
		// hold bits must not be loaded into the counters, or read-hold would stick
		i_brn_host_model.wr(TB, 8'he0);
		for (int i = 1; i < 8; i++)
			i_brn_host_model.wr(TB + 17'(i), SET_IMG[i]);
		i_brn_host_model.wr(TB, 8'h60);
		i_brn_host_model.wr(TB, SET_IMG[0]);
		for (int i = 0; i < 8; i++)
		begin
			i_brn_host_model.rd(TB + 17'(i), 1'b1, q, oe);
			check("set byte", q, SET_IMG[i]);
		end
		// read hold: scribble a visible byte, release must restore counter value
		i_brn_host_model.wr(TB, 8'h60);
		i_brn_host_model.wr(TB + 17'h1, 8'h11);
		i_brn_host_model.rd(TB + 17'h2, 1'b1, q, oe);
		check("held minutes", q, 8'h30);
		i_brn_host_model.wr(TB, 8'h20);
		i_brn_host_model.rd(TB + 17'h1, 1'b1, q, oe);
		check("refreshed seconds", q, 8'h45);
		// frequency test: about four bit-0 edges in 1600 cycles, none once stopped
		i_brn_host_model.wr(TB + 17'h4, 8'h43);
		i_brn_host_model.watch(TB + 17'h1, 1600, tg);
		check("tone edges", {7'h00, tg >= 3 && tg <= 5}, 8'h01);
		i_brn_host_model.wr(TB + 17'h1, 8'hc5);
		i_brn_host_model.watch(TB + 17'h1, 800, tg);
		check("stopped edges", 8'(tg), 8'h00);
		i_brn_host_model.wr(TB + 17'h1, 8'h45);
		i_brn_host_model.wr(TB + 17'h4, 8'h03);
		// power fail: write dropped, read undriven
		power_fail <= 1'b1;
		repeat (4) @(posedge ref_clk);
		i_brn_host_model.wr(17'h00000, 8'h77);
		i_brn_host_model.rd(17'h00000, 1'b1, q, oe);
		check("pf drive", {7'h00, oe}, 8'h00);
		power_fail <= 1'b0;
		repeat (4) @(posedge ref_clk);
		i_brn_host_model.rd(17'h00000, 1'b1, q, oe);
		check("pf write", q, 8'h5a);
		summarize();
	end
endmodule : brn_rtc_top_tb
